//--- scr_regs.sv
`timescale 1ns/1ps
module scr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // SPI pins
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiSdi,
    output logic spiSdo,
    output logic spiSdoEnable,
    // Neighbouring register field
    input wire logic addressAscend,
    // Windowing detector status
    input wire logic [23:0] edgePositionStatus,
    // Sync pin input
    input wire logic syncPin,
    // Clock and sync controls
    output logic syncProcessorEnable,
    output logic syncReceiverEnable,
    output logic windowFineScale,
    output logic [3:0] delaySelect,
    output logic syncPolarityInvert,
    output logic syncInputPeclMode,
    output logic deviceClockPeclMode,
    output logic [7:0] clockControlTwo,
    // Sync path
    output logic syncAligned,
    output logic syncEvent
);
    import scr_pkg::*;

    // Synchronised pins
    logic [3:0] pinSync;
    logic sclkS;
    logic csNS;
    logic sdiS;
    logic syncS;

    scr_sync #(
        .WIDTH(4),
        .STAGES(SYNC_STAGES)
    ) uSync (
        .clk(clk),
        .rst(rst),
        .asyncIn({syncPin, spiSdi, spiCsN, spiSclk}),
        .syncOut(pinSync)
    );

    // Pin copies taken after the two-flop chain
    assign sclkS = pinSync[0];
    assign csNS = pinSync[1];
    assign sdiS = pinSync[2];
    assign syncS = pinSync[3];

    // SPI engine state
    scr_spi_state_type state;
    scr_spi_state_type next_state;
    logic sclkPrev;
    logic next_sclkPrev;
    logic [4:0] bitCount;
    logic [4:0] next_bitCount;
    logic [15:0] shiftIn;
    logic [15:0] next_shiftIn;
    logic readMode;
    logic next_readMode;
    logic [ADDR_W-1:0] address;
    logic [ADDR_W-1:0] next_address;
    logic [7:0] readShift;
    logic [7:0] next_readShift;
    logic sdoBit;
    logic next_sdoBit;
    logic [23:0] edgeSnapshot;
    logic [23:0] next_edgeSnapshot;

    // Register file
    logic [7:0] userSpiConfig;
    logic [7:0] next_userSpiConfig;
    logic [7:0] clockControlZero;
    logic [7:0] next_clockControlZero;
    logic [7:0] clockControlOne;
    logic [7:0] next_clockControlOne;
    logic [7:0] clockControlTwoReg;
    logic [7:0] next_clockControlTwoReg;

    // Sync path state
    logic syncAlignedReg;
    logic next_syncAlignedReg;
    logic syncEventReg;
    logic next_syncEventReg;

    // Edge and strobe decode
    logic sclkRise;
    logic sclkFall;
    logic writeStrobe;
    logic [7:0] writeData;
    logic [ADDR_W-1:0] steppedAddress;
    logic [ADDR_W-1:0] loadAddress;
    logic byteDone;
    logic headerDone;
    logic [ADDR_W-1:0] headerAddress;

    // Serial clock edges; a pulse shorter than a clock period is lost
    assign sclkRise = sclkS && !sclkPrev;
    assign sclkFall = !sclkS && sclkPrev;
    assign headerDone = (state == SPI_HEADER) && sclkRise && !csNS && (bitCount == HEADER_LAST);
    assign byteDone = (state == SPI_DATA) && sclkRise && !csNS && (bitCount == BYTE_LAST);
    // Header address: fourteen shifted bits plus the bit still on the data line
    assign headerAddress = {shiftIn[ADDR_W-2:0], sdiS};
    assign writeStrobe = byteDone && !readMode; // R17
    assign writeData = {shiftIn[6:0], sdiS};

    // Address step between streamed bytes
    always_comb begin
        if (userSpiConfig[ADDRESS_FREEZE_BIT]) begin
            steppedAddress = address; // R02
        end else if (addressAscend) begin
            steppedAddress = address + 15'h0001; // R01 R15
        end else begin
            steppedAddress = address - 15'h0001; // R01 R15
        end
    end

    // Byte read back for a given address
    function automatic logic [7:0] readByte(input logic [ADDR_W-1:0] addr, input logic [23:0] edgeWord);
        logic [7:0] value;
        value = UNMAPPED_READ;
        case (addr)
            USER_SPI_CONFIG_ADDR: value = userSpiConfig;
            CLOCK_CONTROL_ZERO_ADDR: value = clockControlZero;
            CLOCK_CONTROL_ONE_ADDR: value = clockControlOne;
            CLOCK_CONTROL_TWO_ADDR: value = clockControlTwoReg;
            EDGE_STATUS_LOW_ADDR: value = edgeWord[7:0]; // R16
            EDGE_STATUS_MID_ADDR: value = edgeWord[15:8]; // R16
            EDGE_STATUS_HIGH_ADDR: value = edgeWord[23:16]; // R16
            default: value = UNMAPPED_READ;
        endcase
        return value;
    endfunction

    // Address of the next byte to read: header address first, stepped after
    assign loadAddress = headerDone ? headerAddress : steppedAddress;

    // SPI frame sequencing: header, then streamed data bytes
    // Chip select release aborts the frame and drops any partial byte
    always_comb begin
        next_state = state;
        next_sclkPrev = sclkS;
        next_bitCount = bitCount;
        next_shiftIn = shiftIn;
        next_readMode = readMode;
        next_address = address;
        next_readShift = readShift;
        next_sdoBit = sdoBit;
        next_edgeSnapshot = edgeSnapshot;
        if (csNS) begin
            next_state = SPI_IDLE;
            next_bitCount = 5'h00;
            next_sdoBit = 1'b0;
        end else begin
            case (state)
                SPI_IDLE: begin
                    next_state = SPI_HEADER;
                    next_bitCount = 5'h00;
                    if (sclkRise) begin
                        next_shiftIn = {shiftIn[14:0], sdiS};
                        next_bitCount = 5'h01;
                    end
                end
                SPI_HEADER: begin
                    if (sclkRise) begin
                        next_shiftIn = {shiftIn[14:0], sdiS};
                        next_bitCount = bitCount + 5'h01;
                        if (headerDone) begin
                            // Snapshot keeps the three status bytes coherent
                            next_edgeSnapshot = edgePositionStatus;
                            next_readMode = shiftIn[14];
                            next_address = headerAddress;
                            next_readShift = readByte(headerAddress, edgePositionStatus);
                            next_bitCount = 5'h00;
                            next_state = SPI_DATA;
                        end
                    end
                end
                SPI_DATA: begin
                    if (sclkRise) begin
                        next_shiftIn = {shiftIn[14:0], sdiS};
                        next_bitCount = bitCount + 5'h01;
                        if (byteDone) begin
                            next_bitCount = 5'h00;
                            next_address = steppedAddress;
                            next_readShift = readByte(loadAddress, edgeSnapshot);
                        end
                    end else if (sclkFall) begin
                        next_sdoBit = readShift[7];
                        next_readShift = {readShift[6:0], 1'b0};
                    end
                end
                default: begin
                    next_state = SPI_IDLE;
                end
            endcase
        end
    end

    // SPI engine flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= SPI_IDLE;
            sclkPrev <= 1'b0;
            bitCount <= 5'h00;
            shiftIn <= 16'h0000;
            readMode <= 1'b0;
            address <= '0;
            readShift <= 8'h00;
            sdoBit <= 1'b0;
            edgeSnapshot <= EDGE_STATUS_RESET;
        end else begin
            state <= next_state;
            sclkPrev <= next_sclkPrev;
            bitCount <= next_bitCount;
            shiftIn <= next_shiftIn;
            readMode <= next_readMode;
            address <= next_address;
            readShift <= next_readShift;
            sdoBit <= next_sdoBit;
            edgeSnapshot <= next_edgeSnapshot;
        end
    end

    // Register writes; status bytes and unmapped offsets ignore writes
    // Reserved bits are stored as written; the host keeps them at defaults
    always_comb begin
        next_userSpiConfig = userSpiConfig;
        next_clockControlZero = clockControlZero;
        next_clockControlOne = clockControlOne;
        next_clockControlTwoReg = clockControlTwoReg;
        if (writeStrobe) begin
            case (address)
                USER_SPI_CONFIG_ADDR: next_userSpiConfig = writeData; // R17
                CLOCK_CONTROL_ZERO_ADDR: next_clockControlZero = writeData; // R17
                CLOCK_CONTROL_ONE_ADDR: next_clockControlOne = writeData; // R17
                CLOCK_CONTROL_TWO_ADDR: next_clockControlTwoReg = writeData; // R17
                default: next_userSpiConfig = userSpiConfig;
            endcase
        end
    end

    // Register file flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            userSpiConfig <= USER_SPI_CONFIG_RESET;
            clockControlZero <= CLOCK_CONTROL_ZERO_RESET; // R14
            clockControlOne <= CLOCK_CONTROL_ONE_RESET;
            clockControlTwoReg <= CLOCK_CONTROL_TWO_RESET;
        end else begin
            userSpiConfig <= next_userSpiConfig;
            clockControlZero <= next_clockControlZero;
            clockControlOne <= next_clockControlOne;
            clockControlTwoReg <= next_clockControlTwoReg;
        end
    end

    // Control fields driven from the register bits
    assign syncProcessorEnable = clockControlZero[SYNC_PROCESSOR_ENABLE_BIT]; // R04
    assign syncReceiverEnable = clockControlZero[SYNC_RECEIVER_ENABLE_BIT]; // R06
    assign windowFineScale = clockControlZero[WINDOW_FINE_SCALE_BIT]; // R07
    assign delaySelect = clockControlZero[DELAY_SELECT_MSB:DELAY_SELECT_LSB]; // R09
    assign syncPolarityInvert = clockControlOne[SYNC_POLARITY_INVERT_BIT]; // R11
    assign syncInputPeclMode = clockControlOne[SYNC_INPUT_PECL_MODE_BIT]; // R13
    assign deviceClockPeclMode = clockControlOne[DEVICE_CLOCK_PECL_MODE_BIT]; // R12
    assign clockControlTwo = clockControlTwoReg;

    // Sync path: receiver gate, polarity, processor edge event
    // Receiver off holds aligned sync low, so no event can fire either
    always_comb begin
        next_syncAlignedReg = 1'b0;
        next_syncEventReg = 1'b0;
        if (syncReceiverEnable) begin
            next_syncAlignedReg = syncS ^ syncPolarityInvert; // R06 R11
        end
        if (syncProcessorEnable && next_syncAlignedReg && !syncAlignedReg) begin
            next_syncEventReg = 1'b1; // R04
        end
    end

    // Sync path flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            syncAlignedReg <= 1'b0;
            syncEventReg <= 1'b0;
        end else begin
            syncAlignedReg <= next_syncAlignedReg;
            syncEventReg <= next_syncEventReg;
        end
    end

    // Registered sync outputs
    assign syncAligned = syncAlignedReg;
    assign syncEvent = syncEventReg;

    // Serial data out drives only during the data phase of a read
    // Enable low outside reads leaves a shared data line free
    assign spiSdo = sdoBit;
    assign spiSdoEnable = (state == SPI_DATA) && readMode && !csNS;
endmodule

//--- scr_pkg.sv
// Function
// [R01] Freeze clear: address steps per ascend bit
// [R02] Freeze set: streaming address stays constant
// [R03] Host writes zero to user bits 7:1
// [R04] Control zero bit 6 enables sync processor
// [R05] Host enables receiver before or with processor
// [R06] Control zero bit 5 enables sync receiver
// [R07] Bit 4 selects finer windowing delay steps
// [R08] Host sets fine scale at high rates
// [R09] Bits 3:0 select sync capture delay
// [R10] Host picks delay from edge status
// [R11] Control one bit 0 inverts sync polarity
// [R12] Control one bit 2 clock PECL mode
// [R13] Control one bit 1 sync PECL mode
// [R14] Control zero resets to 0x80
// [R15] Ascend bit: 0 decrement, 1 increment
// [R16] Read-only 24-bit edge position status
// [R17] Byte registers written by SPI, read back
package scr_pkg;

    // SPI frame layout
    localparam int ADDR_W = 15;
    localparam int HEADER_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam logic [4:0] HEADER_LAST = 5'h0F;
    localparam logic [4:0] BYTE_LAST = 5'h07;

    // Register offsets
    localparam logic [ADDR_W-1:0] USER_SPI_CONFIG_ADDR = 15'h0010;
    localparam logic [ADDR_W-1:0] CLOCK_CONTROL_ZERO_ADDR = 15'h0029;
    localparam logic [ADDR_W-1:0] CLOCK_CONTROL_ONE_ADDR = 15'h002A;
    localparam logic [ADDR_W-1:0] CLOCK_CONTROL_TWO_ADDR = 15'h002B;
    localparam logic [ADDR_W-1:0] EDGE_STATUS_LOW_ADDR = 15'h002C;
    localparam logic [ADDR_W-1:0] EDGE_STATUS_MID_ADDR = 15'h002D;
    localparam logic [ADDR_W-1:0] EDGE_STATUS_HIGH_ADDR = 15'h002E;

    // Values after reset
    localparam logic [7:0] USER_SPI_CONFIG_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CONTROL_ZERO_RESET = 8'h80;
    localparam logic [7:0] CLOCK_CONTROL_ONE_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CONTROL_TWO_RESET = 8'h10;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [23:0] EDGE_STATUS_RESET = 24'h000000;

    // Field positions
    localparam int ADDRESS_FREEZE_BIT = 0;
    localparam int SYNC_PROCESSOR_ENABLE_BIT = 6;
    localparam int SYNC_RECEIVER_ENABLE_BIT = 5;
    localparam int WINDOW_FINE_SCALE_BIT = 4;
    localparam int DELAY_SELECT_MSB = 3;
    localparam int DELAY_SELECT_LSB = 0;
    localparam int SYNC_POLARITY_INVERT_BIT = 0;
    localparam int SYNC_INPUT_PECL_MODE_BIT = 1;
    localparam int DEVICE_CLOCK_PECL_MODE_BIT = 2;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_HEADER,
        SPI_DATA
    } scr_spi_state_type;

endpackage

//--- scr_sync.sv
`timescale 1ns/1ps
module scr_sync #(
    parameter int WIDTH = 4,
    parameter int STAGES = scr_pkg::SYNC_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous inputs and their synchronised copies
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import scr_pkg::*;

    logic [WIDTH-1:0] stage [STAGES];
    logic [WIDTH-1:0] next_stage [STAGES];

    // Shift chain: first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < STAGES; i++) begin : gStage
            if (i == 0) begin : gFirst
                always_comb begin
                    next_stage[i] = asyncIn;
                end
            end else begin : gRest
                always_comb begin
                    next_stage[i] = stage[i-1];
                end
            end
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    stage[i] <= '0;
                end else begin
                    stage[i] <= next_stage[i];
                end
            end
        end
    endgenerate

    assign syncOut = stage[STAGES-1];
endmodule

//--- scr_regs_props.sv
`timescale 1ns/1ps
module scr_regs_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Pins
    input wire logic spiCsN,
    input wire logic syncPin,
    input wire logic spiSdoEnable,
    // Controls and sync path
    input wire logic syncProcessorEnable,
    input wire logic syncReceiverEnable,
    input wire logic windowFineScale,
    input wire logic [3:0] delaySelect,
    input wire logic syncPolarityInvert,
    input wire logic syncInputPeclMode,
    input wire logic deviceClockPeclMode,
    input wire logic [7:0] clockControlTwo,
    input wire logic syncAligned,
    input wire logic syncEvent
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Controls come out of reset at their defaults
    a_reset_values: assert property (
        $fell(rst) |-> {syncProcessorEnable, syncReceiverEnable, windowFineScale, delaySelect} == 7'h00
        && {syncPolarityInvert, syncInputPeclMode, deviceClockPeclMode} == 3'h0 && clockControlTwo == 8'h10)
        else $error("control not at reset value");
    // Registers change only through a selected frame
    a_zero_hold: assert property (
        spiCsN [*8] |=> $stable({syncProcessorEnable, syncReceiverEnable, windowFineScale, delaySelect}))
        else $error("control zero changed while idle");
    a_one_hold: assert property (
        spiCsN [*8] |=> $stable({syncPolarityInvert, syncInputPeclMode, deviceClockPeclMode}))
        else $error("control one changed while idle");
    a_two_hold: assert property (
        spiCsN [*8] |=> $stable(clockControlTwo)) else $error("control two changed while idle");
    // Receiver off forces the aligned sync low
    a_recv_gate: assert property (
        !syncReceiverEnable |=> !syncAligned) else $error("aligned sync with receiver off");
    // Aligned sync follows the pin through the polarity select
    a_sync_polarity: assert property (
        (syncReceiverEnable && $stable(syncPin) && $stable(syncPolarityInvert)) [*5]
        |-> syncAligned == (syncPin ^ syncPolarityInvert)) else $error("aligned sync polarity wrong");
    // Events are single pulses from a processor that is on
    a_event_pulse: assert property (
        syncEvent |=> !syncEvent) else $error("event longer than one cycle");
    a_event_enable: assert property (
        syncEvent |-> (syncProcessorEnable || $past(syncProcessorEnable)) && (syncAligned || $past(syncAligned)))
        else $error("event without enable or sync");
    // Data out released while deselected
    a_sdo_idle: assert property (
        spiCsN [*6] |-> !spiSdoEnable) else $error("data out driven while deselected");
    c_event: cover property (syncEvent);
    c_read: cover property (spiSdoEnable);
    c_invert: cover property (syncAligned && syncPolarityInvert);
endmodule
bind scr_regs scr_regs_props props_u (.clk, .rst, .spiCsN, .syncPin, .spiSdoEnable, .syncProcessorEnable,
    .syncReceiverEnable, .windowFineScale, .delaySelect, .syncPolarityInvert, .syncInputPeclMode,
    .deviceClockPeclMode, .clockControlTwo, .syncAligned, .syncEvent);

//--- scr_spi_host.sv
`timescale 1ns/1ps
module scr_spi_host (
    // Clock
    input wire logic clk,
    // SPI pins
    output logic spiSclk,
    output logic spiCsN,
    output logic spiSdi,
    input wire logic spiSdo
);
    initial begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiSdi = 1'b0;
    end
    // One bit: data with falling clock, read back late in the low phase, then rising clock
    task automatic bitx(input logic d, output logic q);
        spiSclk <= 1'b0;
        spiSdi <= d;
        repeat (4) @(posedge clk);
        q = spiSdo;
        spiSclk <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    // Whole frame; a bit count that is not a byte multiple aborts in mid-byte
    task automatic frame(input logic rd, input logic [14:0] a, input logic [7:0] wd[$], input int nbits,
                         output logic [7:0] got[$]);
        logic [15:0] hdr;
        logic [7:0] sh;
        logic q;
        hdr = {rd, a};
        got = {};
        sh = 8'h00;
        spiCsN <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 15; i >= 0; i--) bitx(hdr[i], q);
        for (int i = 0; i < nbits; i++) begin
            bitx(rd ? ~spiSdi : wd[i / 8][7 - i % 8], q);
            sh = {sh[6:0], q};
            if (i % 8 == 7) got.push_back(sh);
        end
        spiCsN <= 1'b1;
        spiSdi <= ~spiSdi; // Released line shows no stale value
        repeat (6) @(posedge clk);
    endtask
endmodule

//--- scr_regs_tb_top.sv
`timescale 1ns/1ps
module scr_regs_tb_top;
    import scr_pkg::*;
    logic clk, rst, spiSclk, spiCsN, spiSdi, spiSdo, spiSdoEnable, addressAscend, syncPin;
    logic syncProcessorEnable, syncReceiverEnable, windowFineScale, syncPolarityInvert;
    logic syncInputPeclMode, deviceClockPeclMode, syncAligned, syncEvent;
    logic [23:0] edgePositionStatus;
    logic [3:0] delaySelect;
    logic [7:0] clockControlTwo, v;
    logic [7:0] mdl [int];
    logic sdoLine;
    logic [6:0] zeroFields;
    logic [2:0] oneFields;
    logic [7:0] wq [$], rq [$];
    int errors = 0, total_checks = 0, cycles = 0, events = 0;

    scr_regs dut_u (.clk, .rst, .spiSclk, .spiCsN, .spiSdi, .spiSdo, .spiSdoEnable, .addressAscend,
        .edgePositionStatus, .syncPin, .syncProcessorEnable, .syncReceiverEnable, .windowFineScale,
        .delaySelect, .syncPolarityInvert, .syncInputPeclMode, .deviceClockPeclMode, .clockControlTwo,
        .syncAligned, .syncEvent);
    // Data line seen by the host: pulled high whenever the device does not drive it
    assign sdoLine = (spiSdoEnable === 1'b1) ? spiSdo : 1'b1;
    scr_spi_host host_u (.clk, .spiSclk, .spiCsN, .spiSdi, .spiSdo(sdoLine));
    // Control fields gathered for comparison
    assign zeroFields = {syncProcessorEnable, syncReceiverEnable, windowFineScale, delaySelect};
    assign oneFields = {deviceClockPeclMode, syncInputPeclMode, syncPolarityInvert};

    // Clock, event count and hang limit
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (syncEvent === 1'b1) events++;
        if (cycles == 40000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Model read: status bytes, mapped registers, zero elsewhere
    function automatic logic [7:0] mread(input int a);
        if (a >= 'h2C && a <= 'h2E) return edgePositionStatus[(a - 'h2C) * 8 +: 8];
        return mdl.exists(a) ? mdl[a] : 8'h00;
    endfunction
    // Frame plus model update with address stepping
    task automatic xfer(input logic rd, input int a, input int nbits);
        int p;
        p = a;
        host_u.frame(rd, 15'(a), wq, nbits, rq);
        for (int i = 0; i < nbits / 8; i++) begin
            if (rd) chk($sformatf("read %h", p), mread(p), rq[i]);
            else if (mdl.exists(p)) mdl[p] = wq[i];
            p = mdl['h10][0] ? p : addressAscend ? p + 1 : p - 1;
        end
    endtask
    task automatic wr1(input int a, input logic [7:0] d);
        wq = {d};
        xfer(1'b0, a, 8);
    endtask
    task automatic outs();
        chk("ctrl0 fields", mdl['h29][6:0], zeroFields);
        chk("ctrl1 fields", mdl['h2A][2:0], oneFields);
        chk("ctrl2", mdl['h2B], clockControlTwo);
    endtask
    task automatic toggle(input int n);
        repeat (n) begin
            syncPin <= ~syncPin;
            repeat (8) @(posedge clk);
            chk("aligned", mdl['h29][5] & (syncPin ^ mdl['h2A][0]), syncAligned);
        end
    endtask

    initial begin
        rst = 1'b1;
        addressAscend = 1'b1;
        syncPin = 1'b0;
        edgePositionStatus = 24'h000000;
        void'($urandom(32'h89d0541d));
        mdl['h10] = 8'h00;
        mdl['h29] = 8'h80;
        mdl['h2A] = 8'h00;
        mdl['h2B] = 8'h10;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        outs();
        foreach (mdl[a]) xfer(1'b1, a, 8);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            v = 8'h80 | 8'($urandom());
            wr1('h29, v | {2'b00, v[6], 5'h00});
            wr1('h2A, 8'($urandom()) & 8'h07);
            wr1('h2B, 8'h10 | (8'($urandom()) & 8'h05));
            outs();
            xfer(1'b1, 'h29, 24);
        end
        $display("test fields done");
        wq = {8'h95, 8'h05};
        xfer(1'b0, 'h29, 16);
        addressAscend <= 1'b0;
        wq = {8'h14, 8'h02};
        xfer(1'b0, 'h2B, 16);
        xfer(1'b1, 'h2B, 24);
        addressAscend <= 1'b1;
        wr1('h10, 8'h01);
        wq = {8'h01, 8'h04};
        xfer(1'b0, 'h2A, 16);
        xfer(1'b1, 'h29, 16);
        wr1('h10, 8'h00);
        outs();
        $display("test streaming done");
        edgePositionStatus <= 24'($urandom());
        @(posedge clk);
        wr1('h2C, 8'hA5);
        xfer(1'b1, 'h2C, 24);
        wr1('h05, 8'hFF);
        xfer(1'b1, 'h05, 8);
        wq = {8'h15};
        xfer(1'b0, 'h2B, 5);
        xfer(1'b1, 'h2B, 8);
        $display("test refusals done");
        wr1('h29, 8'hA0);
        wr1('h29, 8'hE0);
        wr1('h2A, 8'h01);
        events = 0;
        toggle(4);
        chk("events on", 2, events);
        wr1('h29, 8'hA0);
        events = 0;
        toggle(2);
        chk("events off", 0, events);
        wr1('h29, 8'h80);
        toggle(2);
        $display("test sync done");
        end_of_test();
    end
endmodule
